// file: common/cpu_map_pkg.sv
// Constants, field layouts and carrier types of the CPU register and memory map.
// Assumes one core clock and one asynchronous reset shared by every user.
`default_nettype none

package cpu_map_pkg;

    // Special function register byte addresses
    localparam logic [7:0] SFR_BASE      = 8'h80;
    localparam logic [7:0] SFR_STACK_PTR = 8'h81;
    localparam logic [7:0] SFR_DATA_POINTER_LOW  = 8'h82;
    localparam logic [7:0] SFR_DATA_POINTER_HIGH = 8'h83;
    localparam logic [7:0] SFR_STATUS    = 8'hD0;
    localparam logic [7:0] SFR_AUX_DATA  = 8'hD4;
    localparam logic [7:0] SFR_AUX_PTR   = 8'hD6;
    localparam logic [7:0] SFR_MAIN_OP   = 8'hE0;
    localparam logic [7:0] SFR_EXT_CTRL  = 8'hE8;
    localparam logic [7:0] SFR_MUL_OP    = 8'hF0;

    // Reset values
    localparam logic [7:0]  STACK_PTR_RESET = 8'h07;
    localparam logic [7:0]  STATUS_RESET    = 8'h00;
    localparam logic [7:0]  EXT_CTRL_RESET  = 8'h00;
    localparam logic [7:0]  AUX_PTR_RESET   = 8'h00;
    localparam logic [7:0]  PC_RESET_HIGH   = 8'hFF;
    localparam logic [7:0]  PC_RESET_LOW    = 8'hFE;

    // Field positions
    localparam int STATUS_UNUSED_BIT = 1;
    localparam int MAP_SELECT_BIT    = 0;
    localparam int BIT_TEST_SRC_BIT  = 6;

    // Memory layout
    localparam logic [7:0] BIT_AREA_BASE  = 8'h20;
    localparam logic [6:0] STACK_LIMIT    = 7'h7F;
    localparam int         IRAM_BYTES     = 256;
    localparam int         AUX_BYTES_DEF  = 256;
    localparam int         ROM_BYTES_DEF  = 32768;

    typedef struct packed {
        logic cy;
        logic ac;
        logic f0;
        logic rs1;
        logic rs0;
        logic ov;
        logic unused;
        logic p;
    } status_word_t;

    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } mem_req_t;

    typedef struct packed {
        logic cy_we;
        logic cy;
        logic ac_we;
        logic ac;
        logic ov_we;
        logic ov;
    } flag_upd_t;

    typedef struct packed {
        logic       rd;
        logic       wr;
        logic       use_data_pointer;
        logic [7:0] index;
        logic [7:0] wdata;
    } xmove_req_t;

endpackage

`default_nettype wire

// file: logic/cpu_register_and_memory_map.sv
// CPU register set, internal RAM, auxiliary RAM and program counter of the core.
// Assumes the core's sequencer issues at most one access per port per cycle.
`default_nettype none

module cpu_register_and_memory_map #(
    parameter int ROM_BYTES = cpu_map_pkg::ROM_BYTES_DEF,
    parameter int AUX_BYTES = cpu_map_pkg::AUX_BYTES_DEF
) (
    input  wire logic                    clk,
    input  wire logic                    sys_rst,
    input  wire cpu_map_pkg::mem_req_t   dir_req,
    output var  logic [7:0]              dir_rdata,
    input  wire cpu_map_pkg::mem_req_t   ind_req,
    output var  logic [7:0]              ind_rdata,
    input  wire cpu_map_pkg::mem_req_t   bit_req,
    output var  logic                    bit_rdata,
    input  wire cpu_map_pkg::mem_req_t   gpr_req,
    output var  logic [7:0]              gpr_rdata,
    input  wire logic                    acc_we,
    input  wire logic [7:0]              acc_wdata,
    input  wire logic                    pair_we,
    input  wire logic [15:0]             pair_wdata,
    output var  logic [15:0]             pair_rdata,
    input  wire cpu_map_pkg::flag_upd_t  flag_upd,
    input  wire logic                    clear_overflow_op,
    input  wire logic                    bit_test_op,
    input  wire logic [7:0]              bit_test_data,
    output var  cpu_map_pkg::status_word_t status_word,
    input  wire logic                    stack_push,
    input  wire logic                    stack_pop,
    output var  logic [7:0]              stack_ptr,
    input  wire logic                    data_pointer_inc,
    output var  logic [15:0]             data_pointer,
    input  wire logic                    pc_load,
    input  wire logic [15:0]             pc_load_val,
    input  wire logic                    pc_inc,
    output var  logic [15:0]             program_counter,
    output var  logic [$clog2(ROM_BYTES)-1:0] rom_addr,
    input  wire cpu_map_pkg::xmove_req_t external_move_op,
    output var  logic [7:0]              xmove_rdata,
    output var  logic                    xmove_hit
);
    import cpu_map_pkg::*;

    localparam int AUX_AW = $clog2(AUX_BYTES);
    localparam int ROM_AW = $clog2(ROM_BYTES);

    // Refuse sizes the address decode cannot serve
    if (AUX_BYTES < 2 || AUX_BYTES > 256 || (1 << AUX_AW) != AUX_BYTES) begin : g_aux_chk
        $error("auxiliary RAM size must be a power of two up to 256");
    end
    if (ROM_BYTES < 2 || ROM_BYTES > 65536 || (1 << ROM_AW) != ROM_BYTES) begin : g_rom_chk
        $error("program memory size must be a power of two up to 65536");
    end

    logic [7:0]        main_operand_register;
    logic [7:0]        multiply_operand_reg;
    logic [7:0]        stack_pointer_reg;
    logic [7:0]        data_pointer_low;
    logic [7:0]        data_pointer_high;
    status_word_t      status_r;
    logic [7:0]        extended_control;
    logic [7:0]        aux_ram_address_pointer;
    logic [15:0]       pc_r;
    logic [7:0]        iram [IRAM_BYTES];
    logic [7:0]        auxiliary_ram [AUX_BYTES];

    logic              parity;
    logic [7:0]        status_rd;
    logic              aux_ram_map_select;
    logic [1:0]        bank;
    logic [7:0]        gpr_addr;
    logic [7:0]        bit_byte_addr;
    logic [7:0]        bit_byte_val;
    logic              bit_is_sfr;
    logic              dir_is_sfr;
    logic              sfr_we;
    logic [7:0]        sfr_waddr;
    logic [7:0]        sfr_wval;
    logic              iram_we;
    logic [7:0]        iram_waddr;
    logic [7:0]        iram_wval;
    logic              port_access;
    logic [AUX_AW-1:0] aux_ptr_idx;
    logic [15:0]       xmove_addr;
    logic              xmove_ok;

    assign parity    = ~(^main_operand_register);
    // fixed order, unassigned bit reads zero
    assign status_rd = {status_r.cy, status_r.ac, status_r.f0, status_r.rs1, status_r.rs0,
                        status_r.ov, 1'b0, parity};

    assign aux_ram_map_select = extended_control[MAP_SELECT_BIT];
    assign aux_ptr_idx        = aux_ram_address_pointer[AUX_AW-1:0];

    assign bank     = {status_r.rs1, status_r.rs0};
    assign gpr_addr = {3'b000, bank, gpr_req.addr[2:0]};

    // high half of direct space is SFR
    assign dir_is_sfr = dir_req.addr[7];
    assign bit_is_sfr = bit_req.addr[7];

    // SFR bits map to xx0/xx8 registers
    // low bits map to bytes 32-47
    always_comb begin
        if (bit_is_sfr) begin
            bit_byte_addr = {bit_req.addr[7:3], 3'b000};
        end else begin
            bit_byte_addr = BIT_AREA_BASE + {4'h0, bit_req.addr[6:3]};
        end
    end

    function automatic logic [7:0] sfr_read(input logic [7:0] a);
        logic [7:0] v;
        v = 8'h00;
        case (a)
            SFR_STACK_PTR: v = stack_pointer_reg;
            SFR_DATA_POINTER_LOW:  v = data_pointer_low;
            SFR_DATA_POINTER_HIGH: v = data_pointer_high;
            SFR_STATUS:    v = status_rd;
            SFR_AUX_DATA:  v = auxiliary_ram[aux_ptr_idx];
            SFR_AUX_PTR:   v = aux_ram_address_pointer;
            SFR_MAIN_OP:   v = main_operand_register;
            SFR_EXT_CTRL:  v = extended_control;
            SFR_MUL_OP:    v = multiply_operand_reg;
            default:       v = 8'h00;
        endcase
        return v;
    endfunction

    // Only xx0/xx8 registers answer bit requests
    function automatic logic [7:0] sfr_bit_byte(input logic [7:0] a);
        logic [7:0] v;
        v = 8'h00;
        if (a[2:0] == 3'b000 && a != SFR_AUX_DATA) begin
            v = sfr_read(a);
        end
        return v;
    endfunction

    always_comb begin
        if (bit_is_sfr) begin
            bit_byte_val = sfr_bit_byte(bit_byte_addr);
        end else begin
            bit_byte_val = iram[bit_byte_addr];
        end
    end

    // One SFR byte write per cycle, direct before bit
    always_comb begin
        sfr_we    = 1'b0;
        sfr_waddr = 8'h00;
        sfr_wval  = 8'h00;
        if (dir_req.wr && dir_is_sfr) begin
            sfr_we    = 1'b1;
            sfr_waddr = dir_req.addr;
            sfr_wval  = dir_req.wdata;
        end else if (bit_req.wr && bit_is_sfr) begin
            sfr_we    = 1'b1;
            sfr_waddr = bit_byte_addr;
            sfr_wval  = bit_byte_val;
            sfr_wval[bit_req.addr[2:0]] = bit_req.wdata[0];
        end
    end

    // indirect reaches all 256 bytes, stack only 00-7F
    always_comb begin
        iram_we    = 1'b0;
        iram_waddr = 8'h00;
        iram_wval  = 8'h00;
        if (dir_req.wr && !dir_is_sfr) begin
            iram_we    = 1'b1;
            iram_waddr = dir_req.addr;
            iram_wval  = dir_req.wdata;
        end else if (ind_req.wr) begin
            iram_we    = 1'b1;
            iram_waddr = ind_req.addr;
            iram_wval  = ind_req.wdata;
        end else if (bit_req.wr && !bit_is_sfr) begin
            iram_we    = 1'b1;
            iram_waddr = bit_byte_addr;
            iram_wval  = bit_byte_val;
            iram_wval[bit_req.addr[2:0]] = bit_req.wdata[0];
        end else if (gpr_req.wr) begin
            iram_we    = 1'b1;
            iram_waddr = gpr_addr;
            iram_wval  = gpr_req.wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (iram_we) begin
            iram[iram_waddr] <= iram_wval;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            main_operand_register <= 8'h00;
        end else if (pair_we) begin
            main_operand_register <= pair_wdata[7:0];
        end else if (acc_we) begin
            main_operand_register <= acc_wdata;
        end else if (sfr_we && sfr_waddr == SFR_MAIN_OP) begin
            main_operand_register <= sfr_wval;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            multiply_operand_reg <= 8'h00;
        end else if (pair_we) begin
            multiply_operand_reg <= pair_wdata[15:8];
        end else if (sfr_we && sfr_waddr == SFR_MUL_OP) begin
            multiply_operand_reg <= sfr_wval;
        end
    end

    assign pair_rdata = {multiply_operand_reg, main_operand_register};

    // push and pop wrap inside 00-7F
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            stack_pointer_reg <= STACK_PTR_RESET;
        end else if (sfr_we && sfr_waddr == SFR_STACK_PTR) begin
            stack_pointer_reg <= {1'b0, sfr_wval[6:0]};
        end else if (stack_push && !stack_pop) begin
            stack_pointer_reg <= {1'b0, (stack_pointer_reg[6:0] + 7'h01) & STACK_LIMIT};
        end else if (stack_pop && !stack_push) begin
            stack_pointer_reg <= {1'b0, (stack_pointer_reg[6:0] - 7'h01) & STACK_LIMIT};
        end
    end

    assign stack_ptr = stack_pointer_reg;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            data_pointer_low  <= 8'h00;
            data_pointer_high <= 8'h00;
        end else if (sfr_we && sfr_waddr == SFR_DATA_POINTER_LOW) begin
            data_pointer_low <= sfr_wval;
        end else if (sfr_we && sfr_waddr == SFR_DATA_POINTER_HIGH) begin
            data_pointer_high <= sfr_wval;
        end else if (data_pointer_inc) begin
            {data_pointer_high, data_pointer_low} <=
                {data_pointer_high, data_pointer_low} + 16'h0001;
        end
    end

    assign data_pointer = {data_pointer_high, data_pointer_low};

    // Status flags: datapath updates win over software writes
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            status_r <= status_word_t'(STATUS_RESET);
        end else begin
            if (sfr_we && sfr_waddr == SFR_STATUS) begin
                status_r.f0  <= sfr_wval[5];
                status_r.rs1 <= sfr_wval[4];
                status_r.rs0 <= sfr_wval[3];
            end
            if (flag_upd.cy_we) begin
                status_r.cy <= flag_upd.cy;
            end else if (sfr_we && sfr_waddr == SFR_STATUS) begin
                status_r.cy <= sfr_wval[7];
            end
            if (flag_upd.ac_we) begin
                status_r.ac <= flag_upd.ac;
            end else if (sfr_we && sfr_waddr == SFR_STATUS) begin
                status_r.ac <= sfr_wval[6];
            end
            // bit test copies memory bit 6
            if (bit_test_op) begin
                status_r.ov <= bit_test_data[BIT_TEST_SRC_BIT];
            end else if (flag_upd.ov_we) begin
                status_r.ov <= flag_upd.ov;
            end else if (clear_overflow_op) begin
                status_r.ov <= 1'b0;
            end else if (sfr_we && sfr_waddr == SFR_STATUS) begin
                status_r.ov <= sfr_wval[2];
            end
            status_r.unused <= 1'b0;
            status_r.p      <= 1'b0;
        end
    end

    assign status_word = status_rd;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            extended_control <= EXT_CTRL_RESET;
        end else if (sfr_we && sfr_waddr == SFR_EXT_CTRL) begin
            extended_control <= {7'h00, sfr_wval[MAP_SELECT_BIT]};
        end
    end

    // data port access bumps the pointer
    assign port_access = dir_is_sfr && dir_req.addr == SFR_AUX_DATA && (dir_req.rd || dir_req.wr);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            aux_ram_address_pointer <= AUX_PTR_RESET;
        end else if (sfr_we && sfr_waddr == SFR_AUX_PTR) begin
            aux_ram_address_pointer <= sfr_wval;
        end else if (port_access) begin
            aux_ram_address_pointer <= aux_ram_address_pointer + 8'h01;
        end
    end

    // data pointer or index, 0-255, select low
    // select high leaves auxiliary RAM alone
    assign xmove_addr = external_move_op.use_data_pointer ? data_pointer
                                                  : {8'h00, external_move_op.index};
    assign xmove_ok   = !aux_ram_map_select && xmove_addr[15:AUX_AW] == '0 && !port_access;

    // no port pins on this path
    always_ff @(posedge clk) begin
        if (port_access && dir_req.wr) begin
            auxiliary_ram[aux_ptr_idx] <= dir_req.wdata;
        end else if (external_move_op.wr && xmove_ok) begin
            auxiliary_ram[xmove_addr[AUX_AW-1:0]] <= external_move_op.wdata;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            xmove_rdata <= 8'h00;
            xmove_hit   <= 1'b0;
        end else begin
            xmove_hit <= (external_move_op.rd || external_move_op.wr) && xmove_ok;
            if (external_move_op.rd && xmove_ok) begin
                xmove_rdata <= auxiliary_ram[xmove_addr[AUX_AW-1:0]];
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            dir_rdata <= 8'h00;
        end else if (dir_req.rd) begin
            dir_rdata <= dir_is_sfr ? sfr_read(dir_req.addr) : iram[dir_req.addr];
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ind_rdata <= 8'h00;
        end else if (ind_req.rd) begin
            ind_rdata <= iram[ind_req.addr];
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            bit_rdata <= 1'b0;
        end else if (bit_req.rd) begin
            bit_rdata <= bit_byte_val[bit_req.addr[2:0]];
        end
    end

    // only active bank reachable by number
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            gpr_rdata <= 8'h00;
        end else if (gpr_req.rd) begin
            gpr_rdata <= iram[gpr_addr];
        end
    end

    // reset vector FFFE, then next address
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pc_r <= {PC_RESET_HIGH, PC_RESET_LOW};
        end else if (pc_load) begin
            pc_r <= pc_load_val;
        end else if (pc_inc) begin
            pc_r <= pc_r + 16'h0001;
        end
    end

    assign program_counter = pc_r;

    assign rom_addr = pc_r[ROM_AW-1:0];

endmodule

`default_nettype wire

// file: tb/cpu_map_properties.sv
// Concurrent checks on the ports of the register and memory map.
// Assumes a single core clock and an active-high asynchronous reset.
`default_nettype none
module cpu_map_properties (
    input wire logic                       clk,
    input wire logic                       sys_rst,
    input wire logic                       pair_we,
    input wire logic [15:0]                pair_wdata,
    input wire logic [15:0]                pair_rdata,
    input wire cpu_map_pkg::flag_upd_t     flag_upd,
    input wire logic                       clear_overflow_op,
    input wire logic                       bit_test_op,
    input wire logic [7:0]                 bit_test_data,
    input wire cpu_map_pkg::status_word_t  status_word,
    input wire logic                       stack_push,
    input wire logic                       stack_pop,
    input wire logic [7:0]                 stack_ptr,
    input wire cpu_map_pkg::mem_req_t      dir_req,
    input wire logic                       pc_load,
    input wire logic                       pc_inc,
    input wire logic [15:0]                program_counter
);
    import cpu_map_pkg::*;
    default clocking dc @(posedge clk); endclocking
    default disable iff (sys_rst);

    // Push alone, with no software write of the pointer
    sequence push_only_s;
        stack_push && !stack_pop && !(dir_req.wr && dir_req.addr == SFR_STACK_PTR);
    endsequence

    parity_flag_a: assert property (status_word.p == ~^pair_rdata[7:0])
        else $error("parity flag wrong");
    status_bit_a: assert property (status_word.unused == 1'b0)
        else $error("unassigned status bit set");
    pair_write_a: assert property (pair_we |=> pair_rdata == $past(pair_wdata))
        else $error("pair write lost");
    ov_test_a: assert property
        (bit_test_op |=> status_word.ov == $past(bit_test_data[BIT_TEST_SRC_BIT]))
        else $error("overflow not loaded by bit test");
    ov_clear_a: assert property
        (clear_overflow_op && !bit_test_op && !flag_upd.ov_we |=> !status_word.ov)
        else $error("overflow not cleared");
    carry_upd_a: assert property (flag_upd.cy_we |=> status_word.cy == $past(flag_upd.cy))
        else $error("carry not updated");
    stack_range_a: assert property (!stack_ptr[7])
        else $error("stack pointer above 7F");
    stack_push_a: assert property
        (push_only_s |=> stack_ptr == {1'b0, $past(stack_ptr[6:0]) + 7'h01})
        else $error("stack push step wrong");
    pc_step_a: assert property
        (pc_inc && !pc_load |=> program_counter == $past(program_counter) + 16'h0001)
        else $error("program counter step wrong");
endmodule

bind cpu_register_and_memory_map cpu_map_properties chk_u (
    .clk, .sys_rst, .pair_we, .pair_wdata, .pair_rdata, .flag_upd, .clear_overflow_op,
    .bit_test_op, .bit_test_data, .status_word, .stack_push, .stack_pop, .stack_ptr,
    .dir_req, .pc_load, .pc_inc, .program_counter
);
`default_nettype wire

// file: tb/cpu_register_and_memory_map_bench.sv
// Self-checking bench of the register and memory map.
// Drives every port itself; expectations come from a small model here.
`default_nettype none
module cpu_register_and_memory_map_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import cpu_map_pkg::*;
    logic clk, sys_rst, acc_we, pair_we, clear_overflow_op, bit_test_op, stack_push;
    logic stack_pop, data_pointer_inc, pc_load, pc_inc, bit_rdata, xmove_hit;
    logic [7:0] acc_wdata, bit_test_data, dir_rdata, ind_rdata, gpr_rdata, stack_ptr;
    logic [7:0] xmove_rdata, v, x, ma, mb, bs;
    logic [15:0] pair_wdata, pair_rdata, data_pointer, pc_load_val, program_counter, w;
    logic [14:0] rom_addr;
    mem_req_t dir_req, ind_req, bit_req, gpr_req;
    flag_upd_t flag_upd;
    status_word_t status_word;
    xmove_req_t external_move_op;
    int failures, compares;
    logic [7:0] aux [256];
    logic [7:0] ra [6] = '{8'h81, 8'h82, 8'h83, 8'hF0, 8'h87, 8'hE8};
    logic [7:0] rm [6] = '{8'h7F, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h01};

    cpu_register_and_memory_map #(.ROM_BYTES(32768), .AUX_BYTES(256)) dut_u (
        .clk, .sys_rst, .dir_req, .dir_rdata, .ind_req, .ind_rdata, .bit_req, .bit_rdata,
        .gpr_req, .gpr_rdata, .acc_we, .acc_wdata, .pair_we, .pair_wdata, .pair_rdata,
        .flag_upd, .clear_overflow_op, .bit_test_op, .bit_test_data, .status_word,
        .stack_push, .stack_pop, .stack_ptr, .data_pointer_inc, .data_pointer, .pc_load,
        .pc_load_val, .pc_inc, .program_counter, .rom_addr, .external_move_op,
        .xmove_rdata, .xmove_hit
    );

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task chk(input string n, input logic [15:0] s, e);
        compares++;
        if (s !== e) begin
            failures++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask

    task end_of_test();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // One-cycle request on port p: 0 direct, 1 indirect, 2 bit, 3 register
    task op(input int p, input logic wr, input logic [7:0] a, d);
        mem_req_t r;
        r = '{rd: !wr, wr: wr, addr: a, wdata: d};
        @(posedge clk);
        case (p)
            0: dir_req <= r;
            1: ind_req <= r;
            2: bit_req <= r;
            default: gpr_req <= r;
        endcase
        @(posedge clk);
        {dir_req, ind_req, bit_req, gpr_req} <= '0;
        #1;
        v = p == 0 ? dir_rdata : p == 1 ? ind_rdata : p == 2 ? {7'h00, bit_rdata} : gpr_rdata;
    endtask

    task xmv(input logic wr, u, input logic [7:0] i, d);
        @(posedge clk) external_move_op <= '{rd: !wr, wr: wr, use_data_pointer: u, index: i, wdata: d};
        @(posedge clk) external_move_op <= '0;
        #1;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        end_of_test();
    end

    initial begin
        failures = 0;
        compares = 0;
        {acc_we, pair_we, clear_overflow_op, bit_test_op, stack_push, stack_pop} = '0;
        {data_pointer_inc, pc_load, pc_inc, acc_wdata, bit_test_data, pair_wdata, pc_load_val} = '0;
        {dir_req, ind_req, bit_req, gpr_req, flag_upd, external_move_op} = '0;
        sys_rst = 1'b1;
        void'($urandom(32'h00477A91));
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            op(0, 0, ra[i], 8'h00);
            chk("reset value", v, i == 0 ? 8'h07 : 8'h00);
        end
        op(0, 0, 8'hD0, 8'h00);
        chk("status reset", v, 8'h01);
        chk("pc reset", program_counter, 16'hFFFE);
        chk("rom addr", rom_addr, 15'h7FFE);
        for (int i = 0; i < 6; i++) begin
            x = 8'($urandom());
            op(0, 1, ra[i], x);
            op(0, 0, ra[i], 8'h00);
            chk("register", v, x & rm[i]);
        end
        op(0, 1, 8'hE8, 8'h00);
        $display("register test done");
        w = 16'($urandom());
        @(posedge clk) begin pair_wdata <= w; pair_we <= 1'b1; end
        @(posedge clk) pair_we <= 1'b0;
        #1 chk("pair", pair_rdata, w);
        op(0, 0, 8'hF0, 8'h00);
        chk("operand", v, w[15:8]);
        mb = w[15:8];
        ma = 8'($urandom());
        @(posedge clk) begin acc_wdata <= ma; acc_we <= 1'b1; end
        @(posedge clk) acc_we <= 1'b0;
        #1 chk("acc", pair_rdata, {mb, ma});
        chk("parity", status_word.p, ~^ma);
        for (int b = 0; b < 4; b++) begin
            x = 8'($urandom());
            op(0, 1, 8'hD0, 8'(b << 3));
            op(3, 1, 8'(b), x);
            op(1, 0, 8'(b * 9), 8'h00);
            chk("bank", v, x);
            op(3, 0, 8'(b), 8'h00);
            chk("register bank", v, x);
        end
        op(0, 0, 8'hD0, 8'h00);
        chk("status", v, {6'h06, 1'b0, ~^ma});
        for (int i = 0; i < 4; i++) begin
            x = 8'($urandom() % 128);
            op(1, 1, 8'h20 + x[6:3], 8'h00);
            op(2, 1, x, 8'h01);
            op(2, 0, x, 8'h00);
            chk("bit read", v, 8'h01);
            op(1, 0, 8'h20 + x[6:3], 8'h00);
            chk("bit area", v, 8'h01 << x[2:0]);
        end
        op(2, 1, 8'hF3, 8'h01);
        op(0, 0, 8'hF0, 8'h00);
        chk("bit sfr", v, mb | 8'h08);
        $display("memory test done");
        bs = 8'($urandom());
        op(0, 1, 8'hD6, bs);
        for (int i = 0; i < 4; i++) begin
            aux[8'(bs + i)] = 8'($urandom());
            op(0, 1, 8'hD4, aux[8'(bs + i)]);
        end
        op(0, 0, 8'hD6, 8'h00);
        chk("aux pointer", v, 8'(bs + 8'h04));
        op(0, 1, 8'hD6, bs);
        for (int i = 0; i < 4; i++) begin
            op(0, 0, 8'hD4, 8'h00);
            chk("aux data", v, aux[8'(bs + i)]);
        end
        op(0, 1, 8'h82, bs + 8'h01);
        op(0, 1, 8'h83, 8'h00);
        chk("data_pointer", data_pointer, {8'h00, bs + 8'h01});
        xmv(0, 1, 8'h00, 8'h00);
        chk("xmove hit", xmove_hit, 1'b1);
        chk("xmove data", xmove_rdata, aux[8'(bs + 1)]);
        @(posedge clk) data_pointer_inc <= 1'b1;
        @(posedge clk) data_pointer_inc <= 1'b0;
        #1 chk("data_pointer step", data_pointer, {8'h00, bs + 8'h01} + 16'h0001);
        x = 8'($urandom());
        xmv(1, 0, bs, x);
        op(0, 1, 8'hD6, bs);
        op(0, 0, 8'hD4, 8'h00);
        chk("xmove write", v, x);
        op(0, 1, 8'h83, 8'h01);
        xmv(0, 1, 8'h00, 8'h00);
        chk("xmove high", xmove_hit, 1'b0);
        op(0, 1, 8'hE8, 8'h01);
        xmv(1, 0, bs, ~x);
        chk("xmove off", xmove_hit, 1'b0);
        op(0, 1, 8'hE8, 8'h00);
        xmv(0, 0, bs, 8'h00);
        chk("aux kept", xmove_rdata, x);
        $display("aux test done");
        for (int i = 0; i < 4; i++) begin
            x = 8'($urandom());
            @(posedge clk) flag_upd <= '{1'b1, x[0], 1'b1, x[1], 1'b1, x[2]};
            @(posedge clk) flag_upd <= '0;
            #1 chk("flags", {status_word.cy, status_word.ac, status_word.ov}, {x[0], x[1], x[2]});
        end
        @(posedge clk) begin bit_test_op <= 1'b1; bit_test_data <= 8'h40; end
        @(posedge clk) begin bit_test_op <= 1'b0; clear_overflow_op <= 1'b1; end
        #1 chk("ov test", status_word.ov, 1'b1);
        @(posedge clk) clear_overflow_op <= 1'b0;
        #1 chk("ov clear", status_word.ov, 1'b0);
        op(0, 1, 8'h81, 8'h7E);
        @(posedge clk) stack_push <= 1'b1;
        @(posedge clk);
        @(posedge clk) stack_push <= 1'b0;
        #1 chk("stack wrap", stack_ptr, 8'h00);
        @(posedge clk) stack_pop <= 1'b1;
        @(posedge clk) stack_pop <= 1'b0;
        #1 chk("stack pop", stack_ptr, 8'h7F);
        w = 16'($urandom());
        @(posedge clk) begin pc_load <= 1'b1; pc_load_val <= w; end
        @(posedge clk) begin pc_load <= 1'b0; pc_inc <= 1'b1; end
        @(posedge clk) pc_inc <= 1'b0;
        #1 chk("pc step", program_counter, w + 16'h0001);
        chk("rom step", rom_addr, 15'(w + 16'h0001));
        $display("datapath test done");
        end_of_test();
    end
endmodule
`default_nettype wire
